// ---- design/smbus_cfg_pkg.sv ----
// constants shared by the configuration target, its host and their link
package smbus_cfg_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_OUTPUT_ENABLE = 8'h00;
	localparam logic [7:0] IDX_PLL_MODE_SWING = 8'h01;
	localparam logic [7:0] IDX_EDGE_RATE = 8'h02;
	localparam logic [7:0] IDX_FREQ_SELECT = 8'h03;
	localparam logic [7:0] IDX_RESERVED_ONES = 8'h04;
	localparam logic [7:0] IDX_REV_VENDOR = 8'h05;
	localparam logic [7:0] IDX_READ_LENGTH = 8'h07;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int POS_STRAP_LO = 32'h0000_0006;
	localparam int POS_MODE_SRC = 32'h0000_0005;
	localparam int POS_MODE_SW_LO = 32'h0000_0003;
	localparam int POS_SWING_LO = 32'h0000_0000;
	localparam int POS_FREQ_EN = 32'h0000_0005;
	localparam int POS_FREQ_LO = 32'h0000_0003;
	localparam int POS_FB_EDGE = 32'h0000_0000;
	localparam int POS_REV_LO = 32'h0000_0004;
	localparam int POS_READ_LEN_LO = 32'h0000_0000;
	localparam logic [7:0] PLL_SWING_RSVD_ONES = 8'h04;
	localparam logic [7:0] FREQ_SELECT_RSVD_ONES = 8'hC6;
	localparam logic [7:0] RESERVED_BYTE_VALUE = 8'hFF;
	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_OUTPUT_ENABLE = 8'hFF;
	localparam logic [1:0] RST_SWING = 2'h2;
	localparam logic [7:0] RST_EDGE_RATE = 8'hFF;
	localparam logic RST_FB_EDGE = 1'h1;
	localparam logic [4:0] RST_READ_LENGTH = 5'h08;
	// ----------------------------------------------------------------
	// link framing and timing
	// ----------------------------------------------------------------
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [3:0] ACK_BIT = 4'h8;
	localparam int CLK_PERIOD_PS = 32'h0000_1F40;
	localparam int SCL_PERIOD_NS = 32'h0000_2710;
	localparam int SCL_QTR_CYCLES =
		(SCL_PERIOD_NS * 32'h0000_03E8 + 32'h0000_0004 * CLK_PERIOD_PS - 32'h0000_0001) /
		(32'h0000_0004 * CLK_PERIOD_PS);
endpackage : smbus_cfg_pkg

// ---- design/smbus_link_if.sv ----
// two-wire link between the configuration host and the target
`timescale 1ns/10ps
interface smbus_link_if;
	logic host_scl_out;
	logic host_scl_oe;
	logic host_sda_out;
	logic host_sda_oe;
	logic dev_sda_out;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	// open-drain wires: any enabled low driver pulls the line down
	assign scl = !(host_scl_oe && !host_scl_out);
	assign sda = !(host_sda_oe && !host_sda_out) && !(dev_sda_oe && !dev_sda_out);

	modport host (output host_scl_out, output host_scl_oe, output host_sda_out,
		output host_sda_oe, input scl, input sda);
	modport device (output dev_sda_out, output dev_sda_oe, input scl, input sda);
endinterface : smbus_link_if

// ---- design/two_entry_buffer.sv ----
// shift-register buffer with valid and ready on both sides
`timescale 1ns/10ps
module two_entry_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input logic clk,
	input logic rst,
	input logic in_valid,
	output logic in_ready,
	input logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [CW-1:0] cnt;
		logic not_empty;
		logic full;
	} buf_state_t;

	buf_state_t st;
	buf_state_t next_st;
	logic pop;
	logic push;

	if (DEPTH < 2 || WIDTH < 1) begin : g_bad_shape
		$error("two_entry_buffer needs DEPTH of 2 or more and WIDTH of 1 or more");
	end

	assign pop = out_ready && st.not_empty;
	assign push = in_valid && !st.full;

	// head entry always at index 0, so the output is a plain register
	always_comb begin
		next_st = st;
		if (pop) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				next_st.mem[i] = st.mem[i + 1];
			end
		end
		next_st.cnt = st.cnt - CW'(pop);
		if (push) begin
			next_st.mem[next_st.cnt] = in_data;
		end
		next_st.cnt = next_st.cnt + CW'(push);
		next_st.not_empty = (next_st.cnt != '0);
		next_st.full = (next_st.cnt == CW'(DEPTH));
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign in_ready = !st.full;
	assign out_valid = st.not_empty;
	assign out_data = st.mem[0];
endmodule : two_entry_buffer

// ---- design/smbus_cfg_target.sv ----
// configuration target: two-wire block protocol and the register bank
`timescale 1ns/10ps
module smbus_cfg_target #(
	parameter logic [6:0] ADDR_SEL_LOW = 7'h2A,
	parameter logic [6:0] ADDR_SEL_HIGH = 7'h2B,
	parameter logic [3:0] REVISION_CODE = 4'h3, // arbitrary value
	parameter logic [3:0] VENDOR_CODE = 4'h9 // arbitrary value
) (
	input logic CLK,
	input logic RST,
	smbus_link_if.device LINK,
	input logic ADDR_SEL,
	input logic [1:0] STRAP_MODE,
	input logic [7:0] PAIR_ENABLE_N,
	output logic [7:0] PAIR_RUN,
	output logic [7:0] PAIR_EDGE_FAST,
	output logic FB_EDGE_FAST,
	output logic [1:0] SWING,
	output logic [1:0] PLL_MODE,
	output logic FREQ_SW_EN,
	output logic [1:0] FREQ_CHOICE
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		D_IDLE = 5'h01,
		D_RX = 5'h02,
		D_ACK = 5'h04,
		D_TX = 5'h08,
		D_TXACK = 5'h10
	} dev_fsm_t;

	typedef enum logic [3:0] {
		B_ADDR = 4'h1,
		B_INDEX = 4'h2,
		B_COUNT = 4'h4,
		B_DATA = 4'h8
	} byte_role_t;

	typedef struct packed {
		dev_fsm_t fsm;
		byte_role_t role;
		logic rd;
		logic [3:0] bits;
		logic [7:0] sh;
		logic [7:0] idx;
		logic sda_low;
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic [1:0] sel_s;
		logic [1:0][1:0] strap_s;
		logic [1:0][7:0] en_s;
		logic [1:0] warm;
		logic taken;
		logic [6:0] my_addr;
		logic [1:0] strap;
		logic [7:0] oe;
		logic mode_src;
		logic [1:0] mode_sw;
		logic [1:0] swing;
		logic [7:0] edge_rate;
		logic freq_en;
		logic [1:0] freq;
		logic fb_edge;
		logic [4:0] rd_len;
		logic [7:0] pair_run;
		logic [1:0] pll_mode;
		logic [1:0] freq_eff;
	} dev_state_t;

	localparam dev_state_t DEV_RESET = '{
		fsm: D_IDLE,
		role: B_ADDR,
		oe: smbus_cfg_pkg::RST_OUTPUT_ENABLE,
		swing: smbus_cfg_pkg::RST_SWING,
		edge_rate: smbus_cfg_pkg::RST_EDGE_RATE,
		fb_edge: smbus_cfg_pkg::RST_FB_EDGE,
		rd_len: smbus_cfg_pkg::RST_READ_LENGTH,
		default: '0
	};

	dev_state_t st;
	dev_state_t next_st;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic sda_bit;
	logic [7:0] rd_value;

	// ----------------------------------------------------------------
	// line events from the synchronised copies
	// ----------------------------------------------------------------
	assign scl_rise = st.scl_s[1] && !st.scl_s[2];
	assign scl_fall = !st.scl_s[1] && st.scl_s[2];
	assign sda_bit = st.sda_s[1];
	assign start_seen = st.scl_s[1] && st.scl_s[2] && !st.sda_s[1] && st.sda_s[2];
	assign stop_seen = st.scl_s[1] && st.scl_s[2] && st.sda_s[1] && !st.sda_s[2];

	// read view of the register bank at the current index
	function automatic logic [7:0] read_reg(input dev_state_t s, input logic [7:0] i);
		logic [7:0] v;
		v = 8'h00;
		if (i == smbus_cfg_pkg::IDX_OUTPUT_ENABLE) begin
			v = s.oe;
		end else if (i == smbus_cfg_pkg::IDX_PLL_MODE_SWING) begin
			v = smbus_cfg_pkg::PLL_SWING_RSVD_ONES
				| (8'(s.strap) << smbus_cfg_pkg::POS_STRAP_LO)
				| (8'(s.mode_src) << smbus_cfg_pkg::POS_MODE_SRC)
				| (8'(s.mode_sw) << smbus_cfg_pkg::POS_MODE_SW_LO)
				| (8'(s.swing) << smbus_cfg_pkg::POS_SWING_LO);
		end else if (i == smbus_cfg_pkg::IDX_EDGE_RATE) begin
			v = s.edge_rate;
		end else if (i == smbus_cfg_pkg::IDX_FREQ_SELECT) begin
			v = smbus_cfg_pkg::FREQ_SELECT_RSVD_ONES
				| (8'(s.freq_en) << smbus_cfg_pkg::POS_FREQ_EN)
				| (8'(s.freq) << smbus_cfg_pkg::POS_FREQ_LO)
				| (8'(s.fb_edge) << smbus_cfg_pkg::POS_FB_EDGE);
		end else if (i == smbus_cfg_pkg::IDX_RESERVED_ONES) begin
			v = smbus_cfg_pkg::RESERVED_BYTE_VALUE;
		end else if (i == smbus_cfg_pkg::IDX_REV_VENDOR) begin
			v = {REVISION_CODE, VENDOR_CODE};
		end else if (i == smbus_cfg_pkg::IDX_READ_LENGTH) begin
			v = 8'(s.rd_len) << smbus_cfg_pkg::POS_READ_LEN_LO;
		end
		return v;
	endfunction : read_reg

	assign rd_value = read_reg(st, st.idx);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		// pins pass two flops before any logic looks at them
		next_st.scl_s = {st.scl_s[1:0], LINK.scl};
		next_st.sda_s = {st.sda_s[1:0], LINK.sda};
		next_st.sel_s = {st.sel_s[0], ADDR_SEL};
		next_st.strap_s = {st.strap_s[0], STRAP_MODE};
		next_st.en_s = {st.en_s[0], PAIR_ENABLE_N};
		next_st.warm = {st.warm[0], 1'b1};

		// address and straps caught once, after the synchronisers fill
		if (!st.taken && st.warm[1]) begin
			next_st.taken = 1'b1;
			next_st.my_addr = st.sel_s[1] ? ADDR_SEL_HIGH : ADDR_SEL_LOW;
			next_st.strap = st.strap_s[1];
		end

		case (st.fsm)
			D_RX: begin
				if (scl_rise) begin
					next_st.sh = {st.sh[6:0], sda_bit};
					next_st.bits = st.bits + 4'h1;
				end else if (scl_fall && st.bits == smbus_cfg_pkg::ACK_BIT) begin
					next_st.bits = 4'h0;
					next_st.fsm = D_ACK;
					next_st.sda_low = 1'b1;
					case (st.role)
						B_ADDR: begin
							// only our own address is answered
							if (st.sh[7:1] == st.my_addr) begin
								next_st.rd = st.sh[0];
							end else begin
								next_st.fsm = D_IDLE;
								next_st.sda_low = 1'b0;
							end
						end
						B_INDEX: begin
							next_st.idx = st.sh;
						end
						B_COUNT: begin
							next_st.sda_low = 1'b1;
						end
						default: begin
							// data byte: store and step the index
							next_st.idx = st.idx + 8'h01;
							if (st.idx == smbus_cfg_pkg::IDX_OUTPUT_ENABLE) begin
								next_st.oe = st.sh;
							end else if (st.idx == smbus_cfg_pkg::IDX_PLL_MODE_SWING) begin
								next_st.mode_src = st.sh[smbus_cfg_pkg::POS_MODE_SRC];
								next_st.mode_sw = st.sh[smbus_cfg_pkg::POS_MODE_SW_LO +: 2];
								next_st.swing = st.sh[smbus_cfg_pkg::POS_SWING_LO +: 2];
							end else if (st.idx == smbus_cfg_pkg::IDX_EDGE_RATE) begin
								next_st.edge_rate = st.sh;
							end else if (st.idx == smbus_cfg_pkg::IDX_FREQ_SELECT) begin
								next_st.freq_en = st.sh[smbus_cfg_pkg::POS_FREQ_EN];
								next_st.freq = st.sh[smbus_cfg_pkg::POS_FREQ_LO +: 2];
								next_st.fb_edge = st.sh[smbus_cfg_pkg::POS_FB_EDGE];
							end else if (st.idx == smbus_cfg_pkg::IDX_READ_LENGTH) begin
								next_st.rd_len = st.sh[smbus_cfg_pkg::POS_READ_LEN_LO +: 5];
							end
						end
					endcase
				end
			end
			D_ACK: begin
				if (scl_fall) begin
					next_st.sda_low = 1'b0;
					next_st.bits = 4'h0;
					if (st.role == B_ADDR && st.rd) begin
						// read begins with the byte count
						next_st.sh = 8'(st.rd_len);
						next_st.sda_low = 1'b1; // count fits in five bits, top bit is zero
						next_st.fsm = D_TX;
					end else begin
						next_st.fsm = D_RX;
						case (st.role)
							B_ADDR: next_st.role = B_INDEX;
							B_INDEX: next_st.role = B_COUNT;
							default: next_st.role = B_DATA;
						endcase
					end
				end
			end
			D_TX: begin
				if (scl_fall) begin
					if (st.bits == smbus_cfg_pkg::LAST_DATA_BIT) begin
						next_st.sda_low = 1'b0;
						next_st.fsm = D_TXACK;
					end else begin
						next_st.sh = {st.sh[6:0], 1'b0};
						next_st.sda_low = !st.sh[6];
						next_st.bits = st.bits + 4'h1;
					end
				end
			end
			D_TXACK: begin
				if (scl_rise && sda_bit) begin
					next_st.fsm = D_IDLE; // host declined further bytes
				end else if (scl_fall) begin
					next_st.sh = rd_value;
					next_st.sda_low = !rd_value[7];
					next_st.idx = st.idx + 8'h01;
					next_st.bits = 4'h0;
					next_st.fsm = D_TX;
				end
			end
			default: begin
				next_st.sda_low = 1'b0;
			end
		endcase

		// start and stop override any byte in flight
		if (!st.taken || stop_seen) begin
			next_st.fsm = D_IDLE;
			next_st.sda_low = 1'b0;
		end else if (start_seen) begin
			next_st.fsm = D_RX;
			next_st.role = B_ADDR;
			next_st.bits = 4'h0;
			next_st.sda_low = 1'b0;
		end

		// registered effects on the clock outputs
		next_st.pair_run = st.oe & ~st.en_s[1];
		next_st.pll_mode = st.mode_src ? st.mode_sw : st.strap;
		next_st.freq_eff = st.freq_en ? st.freq : 2'h0;
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			st <= DEV_RESET;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign LINK.dev_sda_out = 1'b0;
	assign LINK.dev_sda_oe = st.sda_low;
	assign PAIR_RUN = st.pair_run;
	assign PAIR_EDGE_FAST = st.edge_rate;
	assign FB_EDGE_FAST = st.fb_edge;
	assign SWING = st.swing;
	assign PLL_MODE = st.pll_mode;
	assign FREQ_SW_EN = st.freq_en;
	assign FREQ_CHOICE = st.freq_eff;
endmodule : smbus_cfg_target

// ---- design/smbus_cfg_host.sv ----
// host end: block write and block read commands onto the two-wire link
`timescale 1ns/10ps
module smbus_cfg_host #(
	parameter int QTR_CYCLES = smbus_cfg_pkg::SCL_QTR_CYCLES
) (
	input logic CLK,
	input logic RST,
	smbus_link_if.host LINK,
	input logic CMD_VALID,
	output logic CMD_READY,
	input logic CMD_READ,
	input logic [6:0] CMD_TARGET,
	input logic [7:0] CMD_INDEX,
	input logic [7:0] CMD_COUNT,
	input logic WR_VALID,
	output logic WR_READY,
	input logic [7:0] WR_DATA,
	output logic RD_VALID,
	input logic RD_READY,
	output logic [7:0] RD_DATA,
	output logic BUSY,
	output logic ERROR
);
	localparam int TW = $clog2(QTR_CYCLES);

	typedef enum logic [4:0] {
		H_IDLE = 5'h01,
		H_START = 5'h02,
		H_TX = 5'h04,
		H_RX = 5'h08,
		H_STOP = 5'h10
	} host_fsm_t;

	typedef enum logic [6:0] {
		P_ADDRW = 7'h01,
		P_INDEX = 7'h02,
		P_COUNT = 7'h04,
		P_WDATA = 7'h08,
		P_ADDRR = 7'h10,
		P_RCOUNT = 7'h20,
		P_RDATA = 7'h40
	} phase_t;

	typedef struct packed {
		host_fsm_t fsm;
		phase_t ph;
		logic [TW-1:0] tick;
		logic [1:0] q;
		logic [3:0] bits;
		logic [7:0] sh;
		logic rd;
		logic [6:0] target;
		logic [7:0] index;
		logic [7:0] left;
		logic nack;
		logic scl_low;
		logic sda_low;
		logic [1:0] sda_s;
		logic cmd_ready;
		logic wr_ready;
		logic busy;
		logic error;
		logic push;
		logic [7:0] push_data;
	} host_state_t;

	localparam host_state_t HOST_RESET = '{fsm: H_IDLE, ph: P_ADDRW, cmd_ready: 1'b1,
		default: '0};

	host_state_t st;
	host_state_t next_st;
	logic fifo_in_ready;
	logic quarter_end;
	logic stall;

	if (QTR_CYCLES < 2) begin : g_bad_qtr
		$error("smbus_cfg_host needs QTR_CYCLES of 2 or more");
	end

	// -----------------------------------------------------------------
	// pacing: one quarter of a bit per divider pulse
	// -----------------------------------------------------------------
	assign quarter_end = (st.tick == TW'(QTR_CYCLES - 1));
	assign stall = (st.q == 2'h0) && (st.bits == 4'h0) &&
		((st.fsm == H_TX && st.ph == P_WDATA && !WR_VALID) ||
		(st.fsm == H_RX && st.ph == P_RDATA && !fifo_in_ready));

	always_comb begin
		next_st = st;
		next_st.sda_s = {st.sda_s[0], LINK.sda};
		next_st.wr_ready = 1'b0;
		next_st.push = 1'b0;
		if (st.fsm == H_IDLE) begin
			next_st.tick = '0;
			next_st.q = 2'h0;
			if (CMD_VALID) begin
				next_st.cmd_ready = 1'b0;
				next_st.busy = 1'b1;
				next_st.error = 1'b0;
				next_st.rd = CMD_READ;
				next_st.target = CMD_TARGET;
				next_st.index = CMD_INDEX;
				next_st.left = CMD_COUNT;
				next_st.ph = P_ADDRW;
				next_st.fsm = H_START;
			end
		end else if (!stall) begin
			next_st.tick = quarter_end ? '0 : st.tick + TW'(1);
			if (quarter_end) begin
				next_st.q = st.q + 2'h1;
				case (st.fsm)
					H_START: begin
						// also serves as repeated start from a low clock
						case (st.q)
							2'h0: next_st.sda_low = 1'b0;
							2'h1: next_st.scl_low = 1'b0;
							2'h2: next_st.sda_low = 1'b1;
							default: begin
								next_st.scl_low = 1'b1;
								next_st.bits = 4'h0;
								next_st.sh = {st.target, st.ph == P_ADDRR};
								next_st.fsm = H_TX;
							end
						endcase
					end
					H_TX: begin
						case (st.q)
							2'h0: begin
								if (st.ph == P_WDATA && st.bits == 4'h0) begin
									next_st.sh = WR_DATA;
									next_st.wr_ready = 1'b1;
									next_st.sda_low = !WR_DATA[7];
								end else begin
									next_st.sda_low = (st.bits != smbus_cfg_pkg::ACK_BIT) && !st.sh[7];
								end
							end
							2'h1: next_st.scl_low = 1'b0;
							2'h2: begin
								if (st.bits == smbus_cfg_pkg::ACK_BIT) begin
									next_st.nack = st.sda_s[1];
								end
							end
							default: begin
								next_st.scl_low = 1'b1;
								if (st.bits != smbus_cfg_pkg::ACK_BIT) begin
									next_st.sh = {st.sh[6:0], 1'b0};
									next_st.bits = st.bits + 4'h1;
								end else begin
									next_st.bits = 4'h0;
									if (st.nack) begin
										next_st.error = 1'b1;
										next_st.fsm = H_STOP;
									end else begin
										case (st.ph)
											P_ADDRW: begin
												next_st.ph = P_INDEX;
												next_st.sh = st.index;
											end
											P_INDEX: begin
												if (st.rd) begin
													next_st.ph = P_ADDRR;
													next_st.fsm = H_START;
												end else begin
													next_st.ph = P_COUNT;
													next_st.sh = st.left;
												end
											end
											P_COUNT: begin
												next_st.ph = P_WDATA;
												if (st.left == 8'h00) begin
													next_st.fsm = H_STOP;
												end
											end
											P_WDATA: begin
												next_st.left = st.left - 8'h01;
												if (st.left == 8'h01) begin
													next_st.fsm = H_STOP;
												end
											end
											default: begin
												next_st.ph = P_RCOUNT;
												next_st.fsm = H_RX;
											end
										endcase
									end
								end
							end
						endcase
					end
					H_RX: begin
						case (st.q)
							2'h0: begin
								// answer: ack all but the final byte
								if (st.bits != smbus_cfg_pkg::ACK_BIT) begin
									next_st.sda_low = 1'b0;
								end else if (st.ph == P_RCOUNT) begin
									next_st.sda_low = (st.sh != 8'h00);
								end else begin
									next_st.sda_low = (st.left != 8'h01);
								end
							end
							2'h1: next_st.scl_low = 1'b0;
							2'h2: begin
								if (st.bits != smbus_cfg_pkg::ACK_BIT) begin
									next_st.sh = {st.sh[6:0], st.sda_s[1]};
								end
							end
							default: begin
								next_st.scl_low = 1'b1;
								if (st.bits != smbus_cfg_pkg::ACK_BIT) begin
									next_st.bits = st.bits + 4'h1;
								end else begin
									next_st.bits = 4'h0;
									if (st.ph == P_RCOUNT) begin
										next_st.left = st.sh;
										next_st.ph = P_RDATA;
										if (st.sh == 8'h00) begin
											next_st.fsm = H_STOP;
										end
									end else begin
										next_st.push = 1'b1;
										next_st.push_data = st.sh;
										next_st.left = st.left - 8'h01;
										if (st.left == 8'h01) begin
											next_st.fsm = H_STOP;
										end
									end
								end
							end
						endcase
					end
					default: begin
						case (st.q)
							2'h0: next_st.sda_low = 1'b1;
							2'h1: next_st.scl_low = 1'b0;
							2'h2: next_st.sda_low = 1'b0;
							default: begin
								next_st.fsm = H_IDLE;
								next_st.busy = 1'b0;
								next_st.cmd_ready = 1'b1;
							end
						endcase
					end
				endcase
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			st <= HOST_RESET;
		end else begin
			st <= next_st;
		end
	end

	// received data waits here while the user stalls
	two_entry_buffer #(
		.WIDTH(8),
		.DEPTH(2)
	) u_rd_buffer (
		.clk(CLK),
		.rst(RST),
		.in_valid(st.push),
		.in_ready(fifo_in_ready),
		.in_data(st.push_data),
		.out_valid(RD_VALID),
		.out_ready(RD_READY),
		.out_data(RD_DATA)
	);

	assign LINK.host_scl_out = 1'b0;
	assign LINK.host_scl_oe = st.scl_low;
	assign LINK.host_sda_out = 1'b0;
	assign LINK.host_sda_oe = st.sda_low;
	assign CMD_READY = st.cmd_ready;
	assign WR_READY = st.wr_ready;
	assign BUSY = st.busy;
	assign ERROR = st.error;
endmodule : smbus_cfg_host

// ---- dv/smbus_link_sva.sv ----
// wire-level checks on the two-wire link between host and target
`timescale 1ns/10ps
module smbus_link_sva (
	input wire logic CLK,
	input wire logic RST,
	input wire logic host_scl_oe,
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	// ----
	// link timing and framing
	// ----
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);
	a_dev_quiet_reset: assert property ($fell(RST) |-> !dev_sda_oe [*4])
		else $error("target drove data just after reset");
	a_dev_bit_steady: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
		else $error("target moved data while clock high");
	a_dev_moves_late: assert property ($changed(dev_sda_oe) |-> !scl && $past(!scl, 2))
		else $error("target moved data too soon after clock fall");
	a_start_by_host: assert property ($fell(sda) && scl |-> host_sda_oe && !dev_sda_oe)
		else $error("start not made by host alone");
	a_stop_idle_bus: assert property ($rose(sda) && scl |=> scl [*4])
		else $error("clock pulled low right after stop");
	a_scl_low_min: assert property ($fell(scl) |-> !scl [*4])
		else $error("clock low phase too short");
	a_scl_high_min: assert property ($rose(scl) |-> scl [*4])
		else $error("clock high phase too short");
	a_line_steady: assert property (scl && $past(scl) && $stable(host_sda_oe) |-> $stable(sda))
		else $error("data line moved while clock high");
	// main scenarios seen on the wire
	c_start: cover property ($fell(sda) && scl);
	c_ack: cover property ($rose(scl) && dev_sda_oe);
	c_stop: cover property ($rose(sda) && scl);
endmodule : smbus_link_sva

// ---- dv/testbench.sv ----
// host and target joined over the link, driven through host commands
`timescale 1ns/10ps
module testbench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic addr_sel = 1'b0, cmd_valid = 1'b0, cmd_read = 1'b0, wr_valid = 1'b0, rd_ready = 1'b0;
	logic [1:0] strap_mode = 2'h2;
	logic [6:0] cmd_target = 7'h2A;
	logic [7:0] pair_enable_n = 8'h0F, cmd_index = 8'h00, cmd_count = 8'h00, wr_data = 8'h00;
	logic [7:0] pair_run, pair_edge_fast, rd_data;
	logic [1:0] swing, pll_mode, freq_choice;
	logic fb_edge_fast, freq_sw_en, cmd_ready, wr_ready, rd_valid, busy, error;
	logic [7:0] wq[$], rq[$];
	logic [7:0] dflt[8] = '{8'hFF, 8'h86, 8'hFF, 8'hC7, 8'hFF, 8'h39, 8'h00, 8'h08};
	logic [7:0] after[5] = '{8'hBF, 8'h00, 8'hFE, 8'hFF, 8'h39};
	int fail_count = 0, total_checks = 0;
	// ----
	// both ends and the checker
	// ----
	smbus_link_if i_smbus_link_if ();
	smbus_cfg_target i_smbus_cfg_target (.CLK(clk), .RST(rst), .LINK(i_smbus_link_if.device),
		.ADDR_SEL(addr_sel), .STRAP_MODE(strap_mode), .PAIR_ENABLE_N(pair_enable_n),
		.PAIR_RUN(pair_run), .PAIR_EDGE_FAST(pair_edge_fast), .FB_EDGE_FAST(fb_edge_fast),
		.SWING(swing), .PLL_MODE(pll_mode), .FREQ_SW_EN(freq_sw_en), .FREQ_CHOICE(freq_choice));
	smbus_cfg_host #(.QTR_CYCLES(4)) i_smbus_cfg_host (.CLK(clk), .RST(rst),
		.LINK(i_smbus_link_if.host), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
		.CMD_READ(cmd_read), .CMD_TARGET(cmd_target), .CMD_INDEX(cmd_index),
		.CMD_COUNT(cmd_count), .WR_VALID(wr_valid), .WR_READY(wr_ready), .WR_DATA(wr_data),
		.RD_VALID(rd_valid), .RD_READY(rd_ready), .RD_DATA(rd_data), .BUSY(busy), .ERROR(error));
	smbus_link_sva i_smbus_link_sva (.CLK(clk), .RST(rst),
		.host_scl_oe(i_smbus_link_if.host_scl_oe), .host_sda_oe(i_smbus_link_if.host_sda_oe),
		.dev_sda_oe(i_smbus_link_if.dev_sda_oe), .scl(i_smbus_link_if.scl),
		.sda(i_smbus_link_if.sda));
	// ----
	// helpers
	// ----
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : summarize
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one command; feeds write bytes, collects read bytes, reader stalls at first
	task automatic xfer(input logic rd, input logic [6:0] tgt, input logic [7:0] idx,
		input logic [7:0] n);
		@(posedge clk);
		rq.delete();
		cmd_read <= rd;
		cmd_target <= tgt;
		cmd_index <= idx;
		cmd_count <= n;
		cmd_valid <= 1'b1;
		for (int t = 0; t < 20000; t++) begin
			@(negedge clk);
			if (wr_ready) void'(wq.pop_front());
			if (rd_valid && rd_ready) rq.push_back(rd_data);
			if (t > 2 && !busy) break;
			@(posedge clk);
			cmd_valid <= 1'b0;
			wr_valid <= (wq.size() > 0);
			wr_data <= (wq.size() > 0) ? wq[0] : 8'h00;
			rd_ready <= (t > 1200);
		end
		// a command that never finishes counts as a mismatch
		if (busy) begin
			fail_count++;
			summarize();
		end
	endtask : xfer
	// ----
	// clock, watchdog, test sequence
	// ----
	initial begin
		forever #4 clk = ~clk;
	end
	initial begin
		#400000;
		fail_count++;
		summarize();
	end
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (8) @(posedge clk);
		chk(pair_run, 8'hF0);
		chk(pair_edge_fast, 8'hFF);
		chk({fb_edge_fast, freq_sw_en, freq_choice, swing, pll_mode}, 8'h8A);
		xfer(1'b1, 7'h2A, 8'h00, 8'h00);
		chk(8'(rq.size()), 8'h08);
		for (int i = 0; i < 8; i++) chk(rq[i], dflt[i]);
		wq = '{8'h5A, 8'h3B, 8'h00, 8'h38, 8'h00, 8'h00};
		xfer(1'b0, 7'h2A, 8'h00, 8'h06);
		chk({7'h00, error}, 8'h00);
		chk({6'h00, busy, cmd_ready}, 8'h01);
		repeat (6) @(posedge clk);
		chk(pair_run, 8'h50);
		chk(pair_edge_fast, 8'h00);
		chk({fb_edge_fast, freq_sw_en, freq_choice, swing, pll_mode}, 8'h7F);
		wq = '{8'h05};
		xfer(1'b0, 7'h2A, 8'h07, 8'h01);
		xfer(1'b1, 7'h2A, 8'h01, 8'h00);
		chk(8'(rq.size()), 8'h05);
		for (int i = 0; i < 5; i++) chk(rq[i], after[i]);
		wq = '{8'h18};
		xfer(1'b0, 7'h2A, 8'h03, 8'h01);
		repeat (6) @(posedge clk);
		chk({fb_edge_fast, freq_sw_en, freq_choice}, 8'h00);
		xfer(1'b1, 7'h2B, 8'h00, 8'h00);
		chk({7'h00, error}, 8'h01);
		// second reset with the address select pin high
		@(posedge clk);
		addr_sel <= 1'b1;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (8) @(posedge clk);
		chk(pair_run, 8'hF0);
		chk(pair_edge_fast, 8'hFF);
		xfer(1'b1, 7'h2B, 8'h04, 8'h00);
		chk({7'h00, error}, 8'h00);
		chk(8'(rq.size()), 8'h08);
		for (int i = 0; i < 4; i++) chk(rq[i], dflt[i + 4]);
		summarize();
	end
endmodule : testbench
